/* src/crc8_serial.sv */
/*
 Serial 8-bit CRC shift register, one bit per step, MSB first.
 Assumes the user presets it with init before stepping a frame through.
*/
`timescale 1ns/1ps
`include "spi_frame_params.svh"

module crc8_serial (
	input wire logic clock, // System clock
	input wire logic rst, // Asynchronous reset, active high
	crc_step_if.engine port_crc // Control and result
);
	logic [7:0] crc;
	logic [7:0] next_crc;

	// bits enter the low end, polynomial folds back on overflow
	assign next_crc = {crc[6:0], port_crc.din} ^ (crc[7] ? `CRC_POLY : 8'h00);
	assign port_crc.crc = crc;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			crc <= `CRC_SEED_DEFAULT;
		end else if (port_crc.init) begin
			crc <= port_crc.seed;
		end else if (port_crc.step) begin
			crc <= next_crc;
		end
	end
endmodule

/* src/crc_step_if.sv */
/*
 Control and result of one serial CRC engine.
 Assumes the engine and its user share one clock.
*/
`timescale 1ns/1ps

interface crc_step_if;
	logic init;
	logic [7:0] seed;
	logic step;
	logic din;
	logic [7:0] crc;
	modport engine(input init, input seed, input step, input din, output crc);
	modport user(output init, output seed, output step, output din, input crc);
endinterface

/* src/spi_frame_params.svh */
/*
 Constants of the 32-bit sensor data frame: field positions, codes,
 CRC figures and reset values. Included by the package and design files.
*/
`ifndef SPI_FRAME_PARAMS_SVH
`define SPI_FRAME_PARAMS_SVH

`define FRAME_BITS 6'h20
`define MSG_BITS 6'h18
`define CRC_BITS 8
`define CRC_POLY 8'h2F
`define CRC_SEED_DEFAULT 8'hFF
`define CRC_SEED_UPPER 4'hF
`define CMD_MSB 31
`define CMD_LSB 28
`define CMD_REQ_BIT 0
`define REPLY_MARK 1'h1
`define EXTRA_ZERO 4'h0
`define ERROR_REPLY_MSG 24'h0C0000
`define RESERVED_REPLY_MSG 24'h000000
`define SRC_RESET 3'h0
`define CHANNELS 8
`define SAMPLE_BITS 16
`define BIT_CNT_MAX 6'h21

`endif

/* src/spi_frame_pkg.sv */
/*
 Types shared by the sensor frame modules.
 Assumes spi_frame_params.svh is on the include path.
*/
`include "spi_frame_params.svh"

package spi_frame_pkg;
	typedef enum logic [1:0] {REPLY_SENSOR, REPLY_RESERVED, REPLY_ERROR} reply_kind_t;
	typedef enum logic {LINK_IDLE, LINK_FRAME} link_state_t;
	typedef logic [`CHANNELS-1:0][`SAMPLE_BITS-1:0] sample_bank_t;
endpackage

/* src/spi_sensor_frames.sv */
/*
 SPI slave framing for sensor data requests and reserved commands:
 receive, CRC check, decode, and the out-of-frame reply with its CRC.
 The first reply after reset is of the reserved kind.
 Assumes SPI mode 0 from the host, and a link clock at least eight
 times slower than clock; sclk, ss_n and mosi are synchronised here.
*/
`timescale 1ns/1ps
`include "spi_frame_params.svh"

module spi_sensor_frames
	import spi_frame_pkg::*;
(
	input wire logic clock, // System clock, 25 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic sclk, // SPI clock from host
	input wire logic ss_n, // Slave select from host, active low
	input wire logic mosi, // Serial data from host
	output logic miso, // Serial data to host
	output logic miso_oe, // High while miso is driven
	input wire sample_bank_t sample_value, // Sample per data channel
	input wire logic [1:0] basic_health_bits, // Basic status for replies
	input wire logic [1:0] detail_flags, // Detailed status for replies
	input wire logic wide_data_en, // Send extra resolution bits
	input wire logic [3:0] crc_seed_code, // Seed setting, zero for all ones
	output logic cmd_strobe, // One cycle: good command decoded
	output logic [3:0] cmd_code, // Code of last good command
	output logic crc_fail_strobe // One cycle: command rejected
);
	logic sclk_meta;
	logic sclk_s;
	logic sclk_d;
	logic ss_meta;
	logic ss_s;
	logic ss_d;
	logic mosi_meta;
	logic mosi_s;

	link_state_t state;
	link_state_t next_state;

	logic [31:0] rx_shift;
	logic [5:0] rx_cnt;
	logic [31:0] out_shift;
	logic [5:0] out_cnt;
	logic [31:0] feed_shift;
	logic [5:0] feed_cnt;

	reply_kind_t pending_kind;
	logic [2:0] pending_src;

	crc_step_if rx_crc();
	crc_step_if tx_crc();

	// Pin synchronisers, two flops each
	// The third flop of clock and select only feeds the edge detectors
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_meta <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
		end else begin
			sclk_meta <= sclk;
			sclk_s <= sclk_meta;
			sclk_d <= sclk_s;
		end
	end

	// Select resets to its idle level, so reset gives no false frame start
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ss_meta <= 1'b1;
			ss_s <= 1'b1;
			ss_d <= 1'b1;
		end else begin
			ss_meta <= ss_n;
			ss_s <= ss_meta;
			ss_d <= ss_s;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mosi_meta <= 1'b0;
			mosi_s <= 1'b0;
		end else begin
			mosi_meta <= mosi;
			mosi_s <= mosi_meta;
		end
	end

	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;
	wire ss_fall = ~ss_s & ss_d;
	wire ss_rise = ss_s & ~ss_d;
	wire in_frame = (state == LINK_FRAME);
	wire frame_end = in_frame & ss_rise;
	wire frame_start = (state == LINK_IDLE) & ss_fall;

	always_comb begin
		next_state = state;
		case (state)
			LINK_IDLE: begin
				if (ss_fall) begin
					next_state = LINK_FRAME;
				end
			end
			LINK_FRAME: begin
				if (ss_rise) begin
					next_state = LINK_IDLE;
				end
			end
			default: begin
				next_state = LINK_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= LINK_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Receive side: mosi taken on rising SPI clock
	wire rx_take = in_frame & sclk_rise;
	// Bit counters stop at 33 so an overlong frame never wraps back to 32
	wire [5:0] rx_cnt_inc = (rx_cnt == `BIT_CNT_MAX) ? rx_cnt : rx_cnt + 6'h01;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_shift <= 32'h00000000;
			rx_cnt <= 6'h00;
		end else if (frame_start) begin
			rx_cnt <= 6'h00;
		end else if (rx_take) begin
			rx_shift <= {rx_shift[30:0], mosi_s};
			rx_cnt <= rx_cnt_inc;
		end
	end

	// check is always the full 8-bit CRC
	// seed all ones unless the seed setting is non-zero
	wire [7:0] seed_value = (crc_seed_code == 4'h0) ? `CRC_SEED_DEFAULT : {`CRC_SEED_UPPER, crc_seed_code};

	// received frame, CRC included, runs through the checker
	assign rx_crc.init = frame_start;
	assign rx_crc.seed = seed_value;
	assign rx_crc.step = rx_take;
	assign rx_crc.din = mosi_s;

	crc8_serial u_rx_crc (
		.clock(clock),
		.rst(rst),
		.port_crc(rx_crc)
	);

	// wrong length or non-zero remainder means reject
	wire frame_good = (rx_cnt == `FRAME_BITS) & (rx_crc.crc == 8'h00);
	wire [3:0] rx_cmd = rx_shift[`CMD_MSB:`CMD_LSB];
	// lowest command bit marks a sensor data request
	wire rx_is_request = rx_cmd[`CMD_REQ_BIT];
	wire rx_is_reserved = (rx_cmd == 4'h0) | (rx_cmd == 4'h2) | (rx_cmd == 4'h4) |
		(rx_cmd == 4'h6) | (rx_cmd == 4'hA) | (rx_cmd == 4'hE);
	// One cycle after select rises, either accept or reject
	wire accept_now = frame_end & frame_good;
	wire reject_now = frame_end & ~frame_good;

	// the decoded command sets up the next message's reply
	// reserved command answered in the next message too
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pending_kind <= REPLY_RESERVED;
			pending_src <= `SRC_RESET;
		end else if (frame_end) begin
			if (!frame_good) begin
				// drop the command, send the error reply
				pending_kind <= REPLY_ERROR;
			end else if (rx_is_request) begin
				pending_kind <= REPLY_SENSOR;
				pending_src <= rx_cmd[3:1];
			end else if (rx_is_reserved) begin
				// reserved code gets the reserved reply
				pending_kind <= REPLY_RESERVED;
			end else begin
				// Codes handled elsewhere get the same filler reply here
				pending_kind <= REPLY_RESERVED;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmd_strobe <= 1'b0;
			crc_fail_strobe <= 1'b0;
			cmd_code <= 4'h0;
		end else begin
			cmd_strobe <= accept_now;
			crc_fail_strobe <= reject_now;
			if (accept_now) begin
				cmd_code <= rx_cmd;
			end
		end
	end

	// Reply word, taken at the falling edge of slave select
	// sample of the chosen channel as it stands at select fall
	wire [15:0] chosen_sample = sample_value[pending_src];
	// extra resolution only in the wide option
	wire [3:0] extra_bits = wide_data_en ? chosen_sample[3:0] : `EXTRA_ZERO;
	// mark bit and echoed source code
	// sample, extra, detail flags packed left justified
	wire [23:0] sensor_msg = {`REPLY_MARK, pending_src, basic_health_bits,
		chosen_sample[15:4], extra_bits, detail_flags};
	// reserved reply body carries nothing defined
	wire [23:0] reply_msg = (pending_kind == REPLY_SENSOR) ? sensor_msg :
		(pending_kind == REPLY_ERROR) ? `ERROR_REPLY_MSG : `RESERVED_REPLY_MSG;

	// message then eight zeros through the generator
	wire feed_active = in_frame & (feed_cnt != `FRAME_BITS);

	// One bit per clock, so the reply CRC is ready long before bit 24
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			feed_shift <= 32'h00000000;
			feed_cnt <= `FRAME_BITS;
		end else if (frame_start) begin
			feed_shift <= {reply_msg, 8'h00};
			feed_cnt <= 6'h00;
		end else if (feed_active) begin
			feed_shift <= {feed_shift[30:0], 1'b0};
			feed_cnt <= feed_cnt + 6'h01;
		end
	end

	assign tx_crc.init = frame_start;
	assign tx_crc.seed = seed_value;
	assign tx_crc.step = feed_active;
	assign tx_crc.din = feed_shift[31];

	crc8_serial u_tx_crc (
		.clock(clock),
		.rst(rst),
		.port_crc(tx_crc)
	);

	// Transmit side: shifts on falling SPI clock, MSB first
	wire tx_shift_now = in_frame & sclk_fall;
	// The 24th falling edge swaps the CRC into the shift register
	wire crc_slot = (out_cnt == (`MSG_BITS - 6'h01));
	wire [5:0] out_cnt_inc = (out_cnt == `BIT_CNT_MAX) ? out_cnt : out_cnt + 6'h01;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			out_shift <= 32'h00000000;
			out_cnt <= 6'h00;
		end else if (frame_start) begin
			out_shift <= {reply_msg, 8'h00};
			out_cnt <= 6'h00;
		end else if (tx_shift_now) begin
			out_cnt <= out_cnt_inc;
			if (crc_slot) begin
				// close the reply with its own CRC
				out_shift <= {tx_crc.crc, 24'h000000};
			end else begin
				out_shift <= {out_shift[30:0], 1'b0};
			end
		end
	end

	// a reply only leaves when the host runs another message
	assign miso = out_shift[31];
	// Enable follows the framed state, so miso is released between frames
	assign miso_oe = in_frame;
endmodule

/* tb/spi_frames_monitor.sv */
/*
 Pin-level checks of the sensor frame block.
 Assumes sclk half periods of at least three clocks.
*/
`timescale 1ns/1ps

module spi_frames_monitor (
	input wire logic clock, // System clock
	input wire logic rst, // Reset, active high
	input wire logic sclk, // SPI clock
	input wire logic ss_n, // Select, active low
	input wire logic miso, // Reply data
	input wire logic miso_oe, // Reply enable
	input wire logic cmd_strobe, // Good command
	input wire logic [3:0] cmd_code, // Last good code
	input wire logic crc_fail_strobe // Rejected command
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	a_oe_on_select: assert property ($fell(ss_n) |-> ##[2:5] miso_oe)
		else $error("reply enable late");
	a_idle_line_quiet: assert property (ss_n [*6] |-> !miso_oe)
		else $error("reply enable outside frame");
	a_bit_holds_high: assert property (miso_oe && $rose(sclk) |=> $stable(miso) [*3])
		else $error("reply bit moved while sclk high");
	a_strobe_single: assert property (cmd_strobe |=> !cmd_strobe)
		else $error("command pulse too long");
	a_strobes_apart: assert property (!(cmd_strobe && crc_fail_strobe))
		else $error("accept and reject together");
	a_code_needs_strobe: assert property ($changed(cmd_code) |-> cmd_strobe)
		else $error("code changed without accept");
	a_accept_after_frame: assert property (cmd_strobe |-> ss_n && !miso_oe)
		else $error("accept inside frame");
	a_reject_after_frame: assert property (crc_fail_strobe |-> ss_n && !miso_oe)
		else $error("reject inside frame");
	c_accept: cover property (cmd_strobe);
	c_reject: cover property (crc_fail_strobe);
	c_frame: cover property ($rose(miso_oe));
endmodule

bind spi_sensor_frames spi_frames_monitor u_spi_frames_monitor (.clock(clock), .rst(rst), .sclk(sclk),
	.ss_n(ss_n), .miso(miso), .miso_oe(miso_oe), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
	.crc_fail_strobe(crc_fail_strobe));

/* tb/spi_host_model.sv */
/*
 SPI master model, mode 0, 320 ns bit period.
 Assumes a 25 MHz clock.
*/
`timescale 1ns/1ps

module spi_host_model (
	input wire logic clock, // System clock
	output logic sclk = 1'b0, // SPI clock
	output logic ss_n = 1'b1, // Select, active low
	output logic mosi = 1'b0, // Command data
	input wire logic miso_line // Reply line
);
	// each call also collects the previous reply
	task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
		rx = '0;
		@(posedge clock);
		ss_n <= 1'b0;
		mosi <= tx[31];
		repeat (8) @(posedge clock);
		for (int i = 31; i > 31 - nbits; i--) begin
			sclk <= 1'b1;
			rx[i] = miso_line;
			repeat (3) @(posedge clock);
			sclk <= 1'b0;
			tx = tx << 1;
			mosi <= tx[31];
			repeat (5) @(posedge clock);
		end
		ss_n <= 1'b1;
		mosi <= ~mosi;
		repeat (8) @(posedge clock);
	endtask
endmodule

/* tb/tb_spi_sensor_frames.sv */
/*
 Self-checking bench for the sensor frame block.
 Assumes the host model drives the link.
*/
`timescale 1ns/1ps

module tb_spi_sensor_frames;
	import spi_frame_pkg::*;
	logic clock, rst, miso, miso_oe, wide_data_en, cmd_strobe, crc_fail_strobe, sclk, ss_n, mosi, miso_line;
	logic [1:0] basic_health_bits, detail_flags;
	logic [3:0] crc_seed_code, cmd_code;
	sample_bank_t sample_value;
	int err_count = 0;
	int check_count = 0;
	int fail_seen = 0;
	assign miso_line = miso_oe ? miso : ~miso;
	spi_sensor_frames u_spi_sensor_frames (.clock(clock), .rst(rst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .sample_value(sample_value), .basic_health_bits(basic_health_bits),
		.detail_flags(detail_flags), .wide_data_en(wide_data_en), .crc_seed_code(crc_seed_code),
		.cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .crc_fail_strobe(crc_fail_strobe));
	spi_host_model u_spi_host_model (.clock(clock), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso_line(miso_line));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		if (crc_fail_strobe === 1'b1) fail_seen++;
	end
	// serial CRC, eight zeros after 24 bits
	function automatic logic [7:0] crc_of(input logic [23:0] m);
		logic [7:0] r;
		logic [31:0] d;
		r = (crc_seed_code == 4'h0) ? 8'hFF : {4'hF, crc_seed_code};
		d = {m, 8'h00};
		for (int i = 31; i >= 0; i--)
			r = {r[6:0], d[i]} ^ (r[7] ? 8'h2F : 8'h00);
		return r;
	endfunction
	function automatic logic [31:0] sensor_word(input logic [2:0] src);
		logic [15:0] s;
		logic [23:0] m;
		s = sample_value[src];
		m = {1'b1, src, basic_health_bits, s[15:4], wide_data_en ? s[3:0] : 4'h0, detail_flags};
		return {m, crc_of(m)};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic frame(input logic [3:0] c, input logic [19:0] body, input logic [7:0] flip, output logic [31:0] rx);
		u_spi_host_model.xfer({c, body, crc_of({c, body}) ^ flip}, 32, rx);
	endtask
	task automatic t_sweep;
		logic [31:0] rx, exp;
		for (int i = 0; i < 10; i++) begin
			@(posedge clock);
			for (int n = 0; n < 8; n++)
				sample_value[n] <= {i[3:0], n[3:0], 8'h5A};
			basic_health_bits <= i[1:0];
			detail_flags <= ~i[2:1];
			wide_data_en <= i[0];
			crc_seed_code <= (i > 5) ? 4'h5 : 4'h0;
			@(posedge clock);
			exp = sensor_word(3'(i - 1));
			fork
				frame({3'(i), 1'b1}, 20'h0, 8'h00, rx);
				begin
					repeat (20) @(posedge clock);
					sample_value <= ~sample_value;
					basic_health_bits <= ~basic_health_bits;
					detail_flags <= ~detail_flags;
				end
			join
			if (i == 0)
				check(rx[7:0], crc_of(rx[31:8]));
			else
				check(rx, exp);
			check(cmd_code, {3'(i), 1'b1});
		end
	endtask
	task automatic t_bad;
		logic [31:0] rx;
		int f0;
		f0 = fail_seen;
		frame(4'h7, 20'h0, 8'h01, rx);
		u_spi_host_model.xfer(32'hFFFF0000, 16, rx);
		check(rx[31:16], 16'h0C00);
		check(cmd_code, 4'h3);
		frame(4'h5, 20'h0, 8'h00, rx);
		check(rx, {24'h0C0000, crc_of(24'h0C0000)});
		check(fail_seen - f0, 2);
	endtask
	task automatic t_reserved;
		logic [3:0] codes [6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'hA, 4'hE};
		logic [31:0] rx;
		logic [3:0] c;
		for (int i = 0; i < 7; i++) begin
			c = (i < 6) ? codes[i] : 4'h1;
			frame(c, (i < 6) ? 20'hA5C3F ^ 20'(i) : 20'h0, 8'h00, rx);
			check(rx[7:0], crc_of(rx[31:8]));
			check(cmd_code, c);
		end
	endtask
	initial begin
		rst = 1'b1;
		sample_value = '0;
		basic_health_bits = 2'h0;
		detail_flags = 2'h0;
		wide_data_en = 1'b0;
		crc_seed_code = 4'h0;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		t_sweep();
		t_bad();
		t_reserved();
		tally_and_finish();
	end
	initial begin
		#1000000;
		err_count++;
		tally_and_finish();
	end
endmodule
